// ---- hdl/vae_regs.vh ----
// Constants for the logical address and request event block.
// Assumes inclusion by bare name from design files.
`ifndef VAE_REGS_VH
`define VAE_REGS_VH
`define VAE_ADDR_WIDTH      8
`define VAE_ADDR_DYNAMIC    8'hFF
`define VAE_ADDR_ILLEGAL    8'h00
`define VAE_ADDR_RESET      8'h00
`define VAE_LINE_WIDTH      3
`define VAE_LINE_RESET      3'h0
`define VAE_IDENT_VAL       8'h01
`define VAE_STB_WIDTH       8
`define VAE_EVT_NONE        2'h0
`define VAE_EVT_TRUE        2'h1
`define VAE_EVT_FALSE       2'h2
`endif

// ---- hdl/vae_req_level.v ----
// Combined enabled service request level and edge detector.
// Assumes status byte and enable mask are synchronous to mclk_i.
`timescale 1ns/1ps
`include "vae_regs.vh"
module vae_req_level #(
    parameter W = 8
) (
    // Clock and reset
    input  wire         mclk_i,
    input  wire         rst_b_i,
    // Status inputs
    input  wire [W-1:0] stb_i,
    input  wire [W-1:0] sre_i,
    // Level and edges
    output wire         level_o,
    output wire         rise_o,
    output wire         fall_o
);
    reg  [W-1:0] hit_r;
    wire [W-1:0] hit_nxt;
    reg          lvl_r;
    genvar g;
    // ------------------------------------------------------------
    // Per-bit enabled request
    // ------------------------------------------------------------
    generate
        for (g = 0; g < W; g = g + 1) begin : g_bit
            assign hit_nxt[g] = stb_i[g] & sre_i[g];
        end
    endgenerate
    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hit_r <= {W{1'b0}};
            lvl_r <= 1'b0;
        end else begin
            hit_r <= hit_nxt;
            lvl_r <= |hit_r;
        end
    end
    assign level_o = lvl_r;
    assign rise_o  = (|hit_r) & ~lvl_r;
    assign fall_o  = ~(|hit_r) & lvl_r;
endmodule // vae_req_level

// ---- hdl/vae_addr_events.v ----
// Logical address decode and request true / false interrupt events.
// Assumes switch, command and status inputs synchronous to mclk_i.
//
// Summary of operation
// - Eight switches give address or dynamic request
// - All ones selects dynamic, manager assigns address
// - Otherwise switch value is the address
// - Switch on gives one, off zero
// - Switch eight is MSB, one LSB
// - Address zero never accepted
// - One interrupt line, assigned by manager
// - Interrupter identifier reads as one
// - First enabled status bit rising, with none set before, raises request true
// - All enabled causes gone raise request false
`timescale 1ns/1ps
`include "vae_regs.vh"

module vae_addr_events (
    // Clock and reset
    input  wire        mclk_i,
    input  wire        rst_b_i,

    // Address switches, index 0 is switch labelled 1 (on = 1)
    input  wire [7:0]  addr_sw_i,

    // Manager address assignment
    input  wire        addr_assign_i,
    input  wire [7:0]  addr_assign_val_i,

    // Manager interrupter line assignment
    input  wire        line_assign_i,
    input  wire [2:0]  line_assign_val_i,

    // Status byte and service request enable
    input  wire [7:0]  status_byte_i,
    input  wire [7:0]  srq_enable_i,

    // Interrupt acknowledge
    input  wire        irq_ack_i,

    // Configuration outputs
    output wire [7:0]  logical_address_value_o,
    output wire        addr_valid_o,
    output wire        dynamic_cfg_o,
    output wire [7:0]  interrupter_identifier_o,
    output wire [2:0]  int_line_o,
    output wire        line_valid_o,

    // Interrupt request
    output wire        irq_o,
    output wire [1:0]  irq_event_o,
    output wire        req_level_o
);

    // ------------------------------------------------------------
    // Address states
    // ------------------------------------------------------------
    localparam [1:0] ST_CAPTURE  = 2'h0;
    localparam [1:0] ST_STATIC   = 2'h1;
    localparam [1:0] ST_DYN_WAIT = 2'h2;
    localparam [1:0] ST_DYN_SET  = 2'h3;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    reg  [1:0]  addr_st_r;
    reg  [1:0]  addr_st_nxt;
    reg  [7:0]  addr_val_r;
    reg  [7:0]  addr_val_nxt;
    reg         addr_ok_r;
    reg         addr_ok_nxt;
    reg         dyn_r;
    reg         dyn_nxt;

    reg  [2:0]  line_r;
    reg  [2:0]  line_nxt;
    reg         line_ok_r;
    reg         line_ok_nxt;

    reg         irq_r;
    reg         irq_nxt;
    reg  [1:0]  evt_r;
    reg  [1:0]  evt_nxt;

    wire [7:0]  sw_val;
    wire        sw_dyn;
    wire        sw_zero;
    wire        assign_take;
    wire        rise;
    wire        fall;
    wire        evt_true;
    wire        evt_false;

    genvar      g;

    // ------------------------------------------------------------
    // Switch decode
    // ------------------------------------------------------------
    // Each switch feeds its own bit; switch 1 is bit 0, switch 8 bit 7
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_sw
            assign sw_val[g] = addr_sw_i[g];
        end
    endgenerate

    assign sw_dyn  = (sw_val == `VAE_ADDR_DYNAMIC);
    assign sw_zero = (sw_val == `VAE_ADDR_ILLEGAL);

    // Zero assignment ignored so address zero is never used
    assign assign_take = addr_assign_i &&
                         (addr_assign_val_i != `VAE_ADDR_ILLEGAL);

    // ------------------------------------------------------------
    // Address state machine
    // ------------------------------------------------------------
    // Strap is caught once after reset; later switch moves are ignored
    always @* begin
        addr_st_nxt  = addr_st_r;
        addr_val_nxt = addr_val_r;
        addr_ok_nxt  = addr_ok_r;
        dyn_nxt      = dyn_r;
        case (addr_st_r)
            ST_CAPTURE: begin
                dyn_nxt = sw_dyn;
                if (sw_dyn) begin
                    addr_st_nxt = ST_DYN_WAIT;
                end else begin
                    addr_st_nxt = ST_STATIC;
                    if (!sw_zero) begin
                        addr_val_nxt = sw_val;
                        addr_ok_nxt  = 1'b1;
                    end
                end
            end
            ST_STATIC: begin
                // Manager assignments have no effect in static mode
                addr_st_nxt = ST_STATIC;
            end
            ST_DYN_WAIT: begin
                if (assign_take) begin
                    addr_val_nxt = addr_assign_val_i;
                    addr_ok_nxt  = 1'b1;
                    addr_st_nxt  = ST_DYN_SET;
                end
            end
            ST_DYN_SET: begin
                // A later assignment may move the address again
                if (assign_take) begin
                    addr_val_nxt = addr_assign_val_i;
                    addr_ok_nxt  = 1'b1;
                end
            end
            default: begin
                addr_st_nxt  = ST_CAPTURE;
                addr_val_nxt = `VAE_ADDR_RESET;
                addr_ok_nxt  = 1'b0;
                dyn_nxt      = 1'b0;
            end
        endcase
    end

    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            addr_st_r  <= ST_CAPTURE;
            addr_val_r <= `VAE_ADDR_RESET;
            addr_ok_r  <= 1'b0;
            dyn_r      <= 1'b0;
        end else begin
            addr_st_r  <= addr_st_nxt;
            addr_val_r <= addr_val_nxt;
            addr_ok_r  <= addr_ok_nxt;
            dyn_r      <= dyn_nxt;
        end
    end

    assign logical_address_value_o = addr_val_r;
    assign addr_valid_o            = addr_ok_r;
    assign dynamic_cfg_o           = dyn_r;

    // ------------------------------------------------------------
    // Single interrupter line
    // ------------------------------------------------------------
    assign interrupter_identifier_o = `VAE_IDENT_VAL;

    // Any later assignment replaces the line; there is only one
    always @* begin
        line_nxt    = line_r;
        line_ok_nxt = line_ok_r;
        if (line_assign_i) begin
            line_nxt    = line_assign_val_i;
            line_ok_nxt = 1'b1;
        end
    end

    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            line_r    <= `VAE_LINE_RESET;
            line_ok_r <= 1'b0;
        end else begin
            line_r    <= line_nxt;
            line_ok_r <= line_ok_nxt;
        end
    end

    assign int_line_o   = line_r;
    assign line_valid_o = line_ok_r;

    // ------------------------------------------------------------
    // Combined request level
    // ------------------------------------------------------------
    vae_req_level #(
        .W (`VAE_STB_WIDTH)
    ) i_vae_req_level (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_b_i),
        .stb_i   (status_byte_i),
        .sre_i   (srq_enable_i),
        .level_o (req_level_o),
        .rise_o  (rise),
        .fall_o  (fall)
    );

    // Events are dropped until a line exists; the level still tracks
    assign evt_true  = rise & line_ok_r;
    assign evt_false = fall & line_ok_r;

    // ------------------------------------------------------------
    // Interrupt event register
    // ------------------------------------------------------------
    // A new edge replaces a pending one; ack loses to a new event
    always @* begin
        irq_nxt = irq_r;
        evt_nxt = evt_r;
        if (evt_true) begin
            irq_nxt = 1'b1;
            evt_nxt = `VAE_EVT_TRUE;
        end else if (evt_false) begin
            irq_nxt = 1'b1;
            evt_nxt = `VAE_EVT_FALSE;
        end else if (irq_ack_i) begin
            irq_nxt = 1'b0;
            evt_nxt = `VAE_EVT_NONE;
        end
    end

    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_r <= 1'b0;
            evt_r <= `VAE_EVT_NONE;
        end else begin
            irq_r <= irq_nxt;
            evt_r <= evt_nxt;
        end
    end

    assign irq_o       = irq_r;
    assign irq_event_o = evt_r;

endmodule // vae_addr_events

// ---- tb/vae_chk_sva.sv ----
// Port checker for the address and event block.
// Assumes one mclk_i domain; bound below.
`timescale 1ns/1ps
module vae_chk_sva (
    // Clock and reset
    input wire       mclk_i,
    input wire       rst_b_i,
    // Watched inputs
    input wire       addr_assign_i,
    input wire       line_assign_i,
    input wire [7:0] addr_sw_i,
    input wire [7:0] addr_assign_val_i,
    input wire [7:0] status_byte_i,
    input wire [7:0] srq_enable_i,
    input wire [2:0] line_assign_val_i,
    // Watched outputs
    input wire       irq_o,
    input wire       req_level_o,
    input wire       addr_valid_o,
    input wire       dynamic_cfg_o,
    input wire       line_valid_o,
    input wire [7:0] logical_address_value_o,
    input wire [7:0] interrupter_identifier_o,
    input wire [2:0] int_line_o,
    input wire [1:0] irq_event_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    wire hit = |(status_byte_i & srq_enable_i);
    sequence req_on; line_valid_o && $rose(hit); endsequence
    sequence req_off; line_valid_o && $fell(hit); endsequence
    id_one_a: assert property (interrupter_identifier_o == 8'h01) else $error("id");
    no_zero_a: assert property (addr_valid_o |-> logical_address_value_o != 8'h00)
        else $error("zero");
    static_addr_a: assert property ($rose(addr_valid_o) && !dynamic_cfg_o
        |-> logical_address_value_o == $past(addr_sw_i)) else $error("static");
    dyn_addr_a: assert property (dynamic_cfg_o && addr_assign_i && addr_assign_val_i != 8'h00
        |=> addr_valid_o && logical_address_value_o == $past(addr_assign_val_i))
        else $error("dyn");
    line_set_a: assert property (line_assign_i
        |=> line_valid_o && int_line_o == $past(line_assign_val_i)) else $error("line");
    req_true_a: assert property (req_on |-> ##2 irq_o && irq_event_o == 2'h1)
        else $error("true");
    req_false_a: assert property (req_off |-> ##2 irq_o && irq_event_o == 2'h2)
        else $error("false");
    one_event_a: assert property ($rose(irq_o) |-> $changed(req_level_o)) else $error("rep");
endmodule // vae_chk_sva
bind vae_addr_events vae_chk_sva i_chk (.*);

// ---- tb/vae_mgr_model.sv ----
// Manager stand-in: pulses address and line assignments.
// Assumes calls start just after a falling mclk_i edge.
`timescale 1ns/1ps
module vae_mgr_model (
    input  wire       mclk_i,
    output reg        addr_assign_i = 1'b0,
    output reg        line_assign_i = 1'b0,
    output reg  [7:0] addr_assign_val_i = 8'h00,
    output reg  [2:0] line_assign_val_i = 3'h0
);
    // Released value is inverted so a stale value is never seen as held
    // Leading wait keeps one idle cycle between back to back calls
    task give_addr(input [7:0] v);
        @(negedge mclk_i);
        {addr_assign_i, addr_assign_val_i} = {1'b1, v};
        @(negedge mclk_i);
        {addr_assign_i, addr_assign_val_i} = {1'b0, ~v};
    endtask
    task give_line(input [2:0] v);
        @(negedge mclk_i);
        {line_assign_i, line_assign_val_i} = {1'b1, v};
        @(negedge mclk_i);
        {line_assign_i, line_assign_val_i} = {1'b0, ~v};
    endtask
endmodule // vae_mgr_model

// ---- tb/test_vae_addr_events.sv ----
// Bench for the address and event block.
// Assumes 200 MHz mclk_i; inputs move on the falling edge.
`timescale 1ns/1ps
module test_vae_addr_events;
    reg        mclk_i = 1'b0, rst_b_i = 1'b0, irq_ack_i = 1'b0;
    reg  [7:0] addr_sw_i = 8'hFF, status_byte_i = 8'h00, srq_enable_i = 8'h00;
    wire       addr_assign_i, line_assign_i, addr_valid_o, dynamic_cfg_o;
    wire       line_valid_o, irq_o, req_level_o;
    wire [7:0] addr_assign_val_i, logical_address_value_o, interrupter_identifier_o;
    wire [2:0] line_assign_val_i, int_line_o;
    wire [1:0] irq_event_o;
    integer    mismatches = 0, total_checks = 0;
    vae_mgr_model i_vae_mgr_model (.*);
    vae_addr_events i_vae_addr_events (.*);
    initial forever #2.5 mclk_i = ~mclk_i;
    task chk(input ok);
        total_checks = total_checks + 1;
        if (ok !== 1'b1) begin
            mismatches = mismatches + 1;
            $display("ERROR %0t ns: wrong output", $time);
        end
    endtask
    task stop_test;
        $display("mismatches %0d total_checks %0d", mismatches, total_checks);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task boot(input [7:0] sw);
        {rst_b_i, addr_sw_i} = {1'b0, sw};
        repeat (8) @(negedge mclk_i);
        rst_b_i = 1'b1;
        repeat (2) @(negedge mclk_i);
    endtask
    // Ack rides with each status step so every event shows as a fresh rise
    // want is {level, irq, event code}
    task stat(input [7:0] sb, input [3:0] want);
        {irq_ack_i, status_byte_i} = {1'b1, sb};
        @(negedge mclk_i) irq_ack_i = 1'b0;
        @(negedge mclk_i);
        chk(req_level_o === want[3] && irq_o === want[2] &&
            (!want[2] || irq_event_o === want[1:0]));
    endtask
    task t_static;
        boot(8'h01);
        chk(logical_address_value_o === 8'h01 && dynamic_cfg_o === 1'b0);
        i_vae_mgr_model.give_addr(8'h33);
        chk(logical_address_value_o === 8'h01 && addr_valid_o === 1'b1);
        chk(interrupter_identifier_o === 8'h01);
        boot(8'h5A);
        chk(logical_address_value_o === 8'h5A && addr_valid_o === 1'b1);
        boot(8'h80);
        chk(logical_address_value_o === 8'h80 && addr_valid_o === 1'b1);
        boot(8'h00);
        chk(addr_valid_o === 1'b0 && dynamic_cfg_o === 1'b0);
    endtask
    task t_dyn;
        boot(8'hFF);
        chk(dynamic_cfg_o === 1'b1 && addr_valid_o === 1'b0);
        i_vae_mgr_model.give_addr(8'h00);
        chk(addr_valid_o === 1'b0);
        i_vae_mgr_model.give_addr(8'h2A);
        chk(logical_address_value_o === 8'h2A && addr_valid_o === 1'b1);
    endtask
    task t_evt;
        srq_enable_i = 8'h06;
        stat(8'h02, 4'h8);
        stat(8'h00, 4'h0);
        i_vae_mgr_model.give_line(3'h5);
        chk(int_line_o === 3'h5 && line_valid_o === 1'b1);
        stat(8'h01, 4'h0);
        stat(8'h03, 4'hD);
        stat(8'h07, 4'h8);
        stat(8'h05, 4'h8);
        stat(8'h01, 4'h6);
    endtask
    initial begin
        t_static;
        t_dyn;
        t_evt;
        stop_test;
    end
    initial begin
        #5000;
        mismatches = mismatches + 1;
        stop_test;
    end
endmodule // test_vae_addr_events
